// *** op_slice_map.svh ***
// register offsets, field positions and reset values of the instruction slice
`ifndef OP_SLICE_MAP_SVH
`define OP_SLICE_MAP_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_INSTR      8'h00
`define OFS_WREG       8'h04
`define OFS_PROD       8'h08
`define OFS_FLAGS      8'h0C
`define OFS_BANK       8'h10
`define OFS_PC         8'h14
`define OFS_STACK      8'h18
`define OFS_CTRL       8'h1C
`define OFS_INDEX      8'h20
`define OFS_MADDR      8'h24
`define OFS_MDATA      8'h28

// ************************************************************
// field positions
// ************************************************************
`define FLG_C          0
`define FLG_DC         1
`define FLG_Z          2
`define FLG_OV         3
`define FLG_N          4
`define CTRL_EXT       0
`define CTRL_BUSY      8
`define STK_SP_LSB     24

// ************************************************************
// reset values and limits
// ************************************************************
`define RST_BYTE       8'h00
`define RST_FLAGS      5'h00
`define RST_BANK       4'h0
`define RST_PC         21'h000000
`define RST_SP         5'h00
`define RST_ADDR12     12'h000
`define STK_DEPTH      5'h1F
`define IDX_LIMIT      8'h5F
`define ACC_SPLIT      8'h60
`define PC_STEP        21'h000002

`endif

// *** op_pkg.sv ***
// types shared by the instruction slice
package op_pkg;

    // ************************************************************
    // phase and opcode enumerations
    // ************************************************************
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_Q1   = 3'b001,
        PH_Q2   = 3'b010,
        PH_Q3   = 3'b011,
        PH_Q4   = 3'b100
    } phase_t;

    typedef enum logic [3:0] {
        OP_NONE  = 4'b0000,
        OP_MULL  = 4'b0001,
        OP_MULF  = 4'b0010,
        OP_NEG   = 4'b0011,
        OP_POP   = 4'b0100,
        OP_PUSH  = 4'b0101,
        OP_RELATIVE_CALL_OP = 4'b0110,
        OP_RESET = 4'b0111,
        OP_NOP   = 4'b1000
    } op_t;

endpackage : op_pkg

// *** arith_if.sv ***
// carrier between the sequencer and the arithmetic unit
`timescale 1ns/1ns
`default_nettype none

interface arith_if;
    logic        go;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] prod;
    logic [7:0]  neg;
    logic [4:0]  nflags;

    modport core (output go, a, b, input prod, neg, nflags);
    modport unit (input go, a, b, output prod, neg, nflags);
endinterface : arith_if

`default_nettype wire

// *** arith_unit.sv ***
// multiplier and negator of the slice, results latched in the process phase
`timescale 1ns/1ns
`default_nettype none

`include "op_slice_map.svh"

module arith_unit (
    input  wire logic hclk,
    input  wire logic hresetn,
    arith_if.unit     ai
);

    // ************************************************************
    // product and negation
    // ************************************************************
    logic [7:0] neg_d;
    logic [4:0] nflags_d;

    always_comb begin
        neg_d    = 8'(~ai.b + 8'h01);
        nflags_d = '0;
        nflags_d[`FLG_C]  = (ai.b == 8'h00);
        nflags_d[`FLG_DC] = (ai.b[3:0] == 4'h0);
        nflags_d[`FLG_Z]  = (neg_d == 8'h00);
        nflags_d[`FLG_OV] = (ai.b == 8'h80);
        nflags_d[`FLG_N]  = neg_d[7];
    end

    // [RULE1] unsigned full product
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ai.prod   <= 16'h0000;
            ai.neg    <= 8'h00;
            ai.nflags <= 5'h00;
        end else if (ai.go) begin
            ai.prod   <= {8'h00, ai.a} * {8'h00, ai.b};
            ai.neg    <= neg_d;
            ai.nflags <= nflags_d;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_unit_product: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
        ai.go |=> ai.prod == {8'h00, $past(ai.a)} * {8'h00, $past(ai.b)})
        else $error("product does not match operands");
    chk_unit_negflags: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
        ai.go && ai.b == 8'h80 |=> ai.nflags[`FLG_OV] && ai.nflags[`FLG_N] && ai.neg == 8'h80)
        else $error("negation of 80h flags wrong");

endmodule : arith_unit

`default_nettype wire

// *** op_slice.sv ***
// instruction slice: multiply, negate, stack ops, relative call and soft reset
`timescale 1ns/1ns
`default_nettype none

`include "op_slice_map.svh"

// How it works
// [RULE1] literal multiply writes product, accumulator kept
// [RULE2] high byte and low byte to product pair
// [RULE3] file multiply keeps both operands, one cycle
// [RULE4] multiplies leave every status flag alone
// [RULE5] bank bit picks access bank or pointer
// [RULE6] extended mode indexes low file addresses
// [RULE7] negate file in place, five flags updated
// [RULE8] pop drops top stack entry
// [RULE9] push stores PC plus two
// [RULE10] relative call pushes, jumps, one idle cycle
// [RULE11] soft reset restores reset-affected state; the code leaves ext_q and maddr_q at their values
// [RULE12] four phases: decode, read, process, write
module op_slice (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    // ************************************************************
    // state
    // ************************************************************
    op_pkg::phase_t phase_q;
    op_pkg::op_t    op_q;
    logic           idle_cyc_q;
    logic [15:0]    instr_q;
    logic [7:0]     w_q;
    logic [7:0]     prod_hi_q;
    logic [7:0]     prod_lo_q;
    logic [4:0]     flags_q;
    logic [3:0]     bank_q;
    logic [20:0]    pc_q;
    logic [4:0]     sp_q;
    logic [20:0]    stk [1:31];
    logic           ext_q;
    logic [11:0]    index_q;
    logic [11:0]    maddr_q;
    logic [7:0]     mem [0:4095];
    logic [11:0]    ea_q;
    logic [7:0]     opnd_q;
    logic           wr_pend_q;
    logic           rd_pend_q;
    logic [7:0]     dph_addr_q;
    logic [20:0]    stack_top_entry;
    logic           accept;
    logic           bus_wr;
    logic           launch;
    logic           srst;
    logic           busy;

    arith_if ai ();

    arith_unit u_arith (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ai      (ai.unit)
    );

    // ************************************************************
    // functions
    // ************************************************************
    function automatic op_pkg::op_t decode_op(input logic [15:0] ins);
        if (ins[15:8] == 8'h0D)
            return op_pkg::OP_MULL;
        else if (ins[15:9] == 7'b0000001)
            return op_pkg::OP_MULF;
        else if (ins[15:9] == 7'b0110110)
            return op_pkg::OP_NEG;
        else if (ins == 16'h0006)
            return op_pkg::OP_POP;
        else if (ins == 16'h0005)
            return op_pkg::OP_PUSH;
        else if (ins[15:11] == 5'b11011)
            return op_pkg::OP_RELATIVE_CALL_OP;
        else if (ins == 16'h00FF)
            return op_pkg::OP_RESET;
        else if (ins == 16'h0000)
            return op_pkg::OP_NOP;
        else
            return op_pkg::OP_NONE;
    endfunction : decode_op

    function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f, input logic [3:0] bank,
                                             input logic ext, input logic [11:0] idx);
        if (a)
            return {bank, f};
        else if (ext && f <= `IDX_LIMIT)
            return 12'(idx + {4'h0, f});
        else if (f < `ACC_SPLIT)
            return {4'h0, f};
        else
            return {4'hF, f};
    endfunction : eff_addr

    function automatic logic [20:0] call_target(input logic [20:0] pc, input logic [10:0] n);
        return 21'(pc + `PC_STEP + {{9{n[10]}}, n, 1'b0});
    endfunction : call_target

    function automatic logic reg_hit(input logic [7:0] ofs);
        return bus_wr && dph_addr_q == ofs;
    endfunction : reg_hit

    // ************************************************************
    // bus slave
    // ************************************************************
    assign accept    = hsel && htrans[1] && hready;
    assign bus_wr    = wr_pend_q;
    assign hreadyout = !rd_pend_q;
    assign hresp     = 1'b0;
    assign busy      = phase_q != op_pkg::PH_IDLE;
    assign launch    = bus_wr && dph_addr_q == `OFS_INSTR && !busy;
    assign stack_top_entry       = (sp_q == `RST_SP) ? `RST_PC : stk[sp_q];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q  <= 1'b0;
            rd_pend_q  <= 1'b0;
            dph_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= accept && hwrite;
            rd_pend_q <= accept && !hwrite;
            if (accept)
                dph_addr_q <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend_q) begin
            case (dph_addr_q)
                `OFS_INSTR: hrdata <= {16'h0000, instr_q};
                `OFS_WREG:  hrdata <= {24'h000000, w_q};
                `OFS_PROD:  hrdata <= {16'h0000, prod_hi_q, prod_lo_q};
                `OFS_FLAGS: hrdata <= {27'h0000000, flags_q};
                `OFS_BANK:  hrdata <= {28'h0000000, bank_q};
                `OFS_PC:    hrdata <= {11'h000, pc_q};
                `OFS_STACK: hrdata <= {3'h0, sp_q, 3'h0, stack_top_entry};
                `OFS_CTRL:  hrdata <= {23'h000000, busy, 7'h00, ext_q};
                `OFS_INDEX: hrdata <= {20'h00000, index_q};
                `OFS_MADDR: hrdata <= {20'h00000, maddr_q};
                `OFS_MDATA: hrdata <= {24'h000000, mem[maddr_q]};
                default:    hrdata <= 32'h00000000;
            endcase
        end
    end

    // ************************************************************
    // phase sequencer
    // ************************************************************
    // [RULE12] four phases per cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= op_pkg::PH_IDLE;
        end else begin
            case (phase_q)
                op_pkg::PH_IDLE: phase_q <= launch ? op_pkg::PH_Q1 : op_pkg::PH_IDLE;
                op_pkg::PH_Q1:   phase_q <= op_pkg::PH_Q2;
                op_pkg::PH_Q2:   phase_q <= op_pkg::PH_Q3;
                op_pkg::PH_Q3:   phase_q <= op_pkg::PH_Q4;
                op_pkg::PH_Q4: begin
                    // [RULE10] second cycle idles
                    if (op_q == op_pkg::OP_RELATIVE_CALL_OP && !idle_cyc_q)
                        phase_q <= op_pkg::PH_Q1;
                    else
                        phase_q <= op_pkg::PH_IDLE;
                end
                default:         phase_q <= op_pkg::PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_cyc_q <= 1'b0;
        end else if (phase_q == op_pkg::PH_Q4) begin
            idle_cyc_q <= op_q == op_pkg::OP_RELATIVE_CALL_OP && !idle_cyc_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_q <= 16'h0000;
            op_q    <= op_pkg::OP_NONE;
        end else begin
            if (launch)
                instr_q <= hwdata[15:0];
            if (phase_q == op_pkg::PH_Q1 && !idle_cyc_q)
                op_q <= decode_op(instr_q);
        end
    end

    // ************************************************************
    // operand address and read
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ea_q   <= `RST_ADDR12;
            opnd_q <= `RST_BYTE;
        end else begin
            // [RULE5] bank selection
            // [RULE6] indexed literal offset
            if (phase_q == op_pkg::PH_Q1)
                ea_q <= eff_addr(instr_q[8], instr_q[7:0], bank_q, ext_q, index_q);
            // [RULE3] operand read only
            if (phase_q == op_pkg::PH_Q2)
                opnd_q <= (op_q == op_pkg::OP_MULL) ? instr_q[7:0] : mem[ea_q];
        end
    end

    assign ai.go = phase_q == op_pkg::PH_Q3 && !idle_cyc_q;
    assign ai.a  = w_q;
    assign ai.b  = opnd_q;

    // [RULE11] reset starts in the read phase
    assign srst = phase_q == op_pkg::PH_Q2 && op_q == op_pkg::OP_RESET && !idle_cyc_q;

    // ************************************************************
    // result write-back
    // ************************************************************
    // [RULE2] product pair update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prod_hi_q <= `RST_BYTE;
            prod_lo_q <= `RST_BYTE;
        end else if (srst) begin
            prod_hi_q <= `RST_BYTE;
            prod_lo_q <= `RST_BYTE;
        end else if (phase_q == op_pkg::PH_Q4 &&
                     (op_q == op_pkg::OP_MULL || op_q == op_pkg::OP_MULF) && !idle_cyc_q) begin
            prod_hi_q <= ai.prod[15:8];
            prod_lo_q <= ai.prod[7:0];
        end else if (reg_hit(`OFS_PROD)) begin
            prod_hi_q <= hwdata[15:8];
            prod_lo_q <= hwdata[7:0];
        end
    end

    // [RULE4] only negate, soft reset and bus writes to the flags register touch flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            flags_q <= `RST_FLAGS;
        else if (srst)
            flags_q <= `RST_FLAGS;
        else if (phase_q == op_pkg::PH_Q4 && op_q == op_pkg::OP_NEG && !idle_cyc_q)
            flags_q <= ai.nflags;
        else if (reg_hit(`OFS_FLAGS))
            flags_q <= hwdata[4:0];
    end

    // [RULE7] negation written back
    always_ff @(posedge hclk) begin
        if (phase_q == op_pkg::PH_Q4 && op_q == op_pkg::OP_NEG && !idle_cyc_q)
            mem[ea_q] <= ai.neg;
        else if (reg_hit(`OFS_MDATA))
            mem[maddr_q] <= hwdata[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_q     <= `RST_BYTE;
            bank_q  <= `RST_BANK;
            index_q <= `RST_ADDR12;
        end else if (srst) begin
            w_q     <= `RST_BYTE;
            bank_q  <= `RST_BANK;
            index_q <= `RST_ADDR12;
        end else begin
            if (reg_hit(`OFS_WREG))
                w_q <= hwdata[7:0];
            if (reg_hit(`OFS_BANK))
                bank_q <= hwdata[3:0];
            if (reg_hit(`OFS_INDEX))
                index_q <= hwdata[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_q   <= 1'b0;
            maddr_q <= `RST_ADDR12;
        end else begin
            if (reg_hit(`OFS_CTRL))
                ext_q <= hwdata[`CTRL_EXT];
            if (reg_hit(`OFS_MADDR))
                maddr_q <= hwdata[11:0];
        end
    end

    // ************************************************************
    // program counter and return stack
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q <= `RST_PC;
        end else if (srst) begin
            pc_q <= `RST_PC;
        end else if (phase_q == op_pkg::PH_Q4 && !idle_cyc_q && op_q != op_pkg::OP_RESET) begin
            // [RULE10] jump to PC+2+2n
            if (op_q == op_pkg::OP_RELATIVE_CALL_OP)
                pc_q <= call_target(pc_q, instr_q[10:0]);
            else
                pc_q <= 21'(pc_q + `PC_STEP);
        end else if (reg_hit(`OFS_PC)) begin
            pc_q <= {hwdata[20:1], 1'b0};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_q <= `RST_SP;
        end else if (srst) begin
            sp_q <= `RST_SP;
        end else if (phase_q == op_pkg::PH_Q2 && !idle_cyc_q &&
                     (op_q == op_pkg::OP_PUSH || op_q == op_pkg::OP_RELATIVE_CALL_OP) && sp_q != `STK_DEPTH) begin
            sp_q <= 5'(sp_q + 5'h01);
        // [RULE8] pop discards top
        end else if (phase_q == op_pkg::PH_Q3 && op_q == op_pkg::OP_POP && !idle_cyc_q &&
                     sp_q != `RST_SP) begin
            sp_q <= 5'(sp_q - 5'h01);
        end
    end

    // [RULE9] push PC plus two
    always_ff @(posedge hclk) begin
        if (phase_q == op_pkg::PH_Q2 && !idle_cyc_q && !srst &&
            (op_q == op_pkg::OP_PUSH || op_q == op_pkg::OP_RELATIVE_CALL_OP) && sp_q != `STK_DEPTH)
            stk[5'(sp_q + 5'h01)] <= 21'(pc_q + `PC_STEP);
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic q4_now;
    assign q4_now = phase_q == op_pkg::PH_Q4 && !idle_cyc_q;

    chk_mull_product: assert property (q4_now && op_q == op_pkg::OP_MULL |=> // [RULE1]
        {prod_hi_q, prod_lo_q} == {8'h00, $past(w_q)} * {8'h00, $past(instr_q[7:0])} && w_q == $past(w_q))
        else $error("literal multiply result wrong");
    chk_prod_bytes: assert property (q4_now && op_q == op_pkg::OP_MULF |=> // [RULE2]
        prod_hi_q == $past(ai.prod[15:8]) && prod_lo_q == $past(ai.prod[7:0]))
        else $error("product bytes swapped");
    chk_mulf_keep: assert property (phase_q == op_pkg::PH_Q1 && decode_op(instr_q) == op_pkg::OP_MULF // [RULE3]
        && !idle_cyc_q |-> ##4 phase_q == op_pkg::PH_IDLE && mem[ea_q] == opnd_q
        && {prod_hi_q, prod_lo_q} == {8'h00, w_q} * {8'h00, opnd_q})
        else $error("file multiply wrong");
    chk_mul_flags: assert property (q4_now && (op_q == op_pkg::OP_MULL || op_q == op_pkg::OP_MULF) // [RULE4]
        |=> $stable(flags_q))
        else $error("multiply changed flags");
    chk_bank_sel: assert property (phase_q == op_pkg::PH_Q1 && instr_q[8] |=> // [RULE5]
        ea_q == {bank_q, instr_q[7:0]})
        else $error("banked address wrong");
    chk_index_mode: assert property (phase_q == op_pkg::PH_Q1 && !instr_q[8] && ext_q // [RULE6]
        && instr_q[7:0] <= `IDX_LIMIT |=> ea_q == 12'(index_q + {4'h0, instr_q[7:0]}))
        else $error("indexed address wrong");
    chk_neg_write: assert property (q4_now && op_q == op_pkg::OP_NEG |=> // [RULE7]
        mem[ea_q] == 8'(8'h00 - opnd_q) && flags_q[`FLG_Z] == (opnd_q == 8'h00))
        else $error("negate result wrong");
    chk_pop_depth: assert property (phase_q == op_pkg::PH_Q3 && op_q == op_pkg::OP_POP // [RULE8]
        && !idle_cyc_q && sp_q != `RST_SP |=> sp_q == 5'($past(sp_q) - 5'h01))
        else $error("pop depth wrong");
    chk_push_value: assert property (phase_q == op_pkg::PH_Q2 && op_q == op_pkg::OP_PUSH // [RULE9]
        && sp_q != `STK_DEPTH |=> stack_top_entry == 21'($past(pc_q) + `PC_STEP))
        else $error("push value wrong");
    chk_relative_call_op_jump: assert property (q4_now && op_q == op_pkg::OP_RELATIVE_CALL_OP |=> // [RULE10]
        pc_q == call_target($past(pc_q), $past(instr_q[10:0])) ##4 phase_q == op_pkg::PH_IDLE)
        else $error("relative call wrong");
    chk_soft_reset: assert property (srst |=> w_q == `RST_BYTE && sp_q == `RST_SP // [RULE11]
        && pc_q == `RST_PC && flags_q == `RST_FLAGS)
        else $error("software reset incomplete");
    chk_phase_walk: assert property (phase_q == op_pkg::PH_Q1 |=> // [RULE12]
        phase_q == op_pkg::PH_Q2 ##1 phase_q == op_pkg::PH_Q3 ##1 phase_q == op_pkg::PH_Q4)
        else $error("phase order broken");

    cov_mull:  cover property (q4_now && op_q == op_pkg::OP_MULL);
    cov_neg:   cover property (q4_now && op_q == op_pkg::OP_NEG && opnd_q == 8'h80);
    cov_relative_call_op: cover property (phase_q == op_pkg::PH_Q4 && idle_cyc_q);
    cov_reset: cover property (srst);

endmodule : op_slice

`default_nettype wire

// *** tb.sv ***
// self-checking bench of the instruction slice
`timescale 1ns/1ns
`default_nettype none
`include "op_slice_map.svh"
module tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    int          n_mismatch;
    int          n_tests;
    int          sp;
    logic [31:0] rd;
    logic [20:0] pc;
    logic [20:0] tosq [0:7];
    logic [15:0] op;
    logic [11:0] idx;
    logic [11:0] ma;
    logic [7:0]  w;
    logic [7:0]  v;
    logic [7:0]  f;
    logic [3:0]  bk;
    logic        ext;
    logic [7:0]  zoff [0:7];

    op_slice dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    // ************************************************************
    // expectations and bus cycles
    // ************************************************************
    function automatic logic [15:0] mulx(input logic [7:0] a, input logic [7:0] b);
        return a * b;
    endfunction : mulx

    function automatic logic [11:0] ea(input logic a, input logic [7:0] fa);
        if (a) return {bk, fa};
        if (ext && fa <= 8'h5F) return idx + {4'h0, fa};
        return {(fa < 8'h60) ? 4'h0 : 4'hF, fa};
    endfunction : ea

    function automatic logic [31:0] nfl(input logic [7:0] x);
        logic [7:0] r;
        r = -x;
        return {27'h0, r[7], x == 8'h80, r == 8'h00, x[3:0] == 4'h0, x == 8'h00};
    endfunction : nfl

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        bus(1'b0, a, 32'h00000000);
    endtask : rdr

    task automatic exec(input logic [15:0] o);
        int c;
        c = 0;
        wr(`OFS_INSTR, {16'h0000, o});
        rdr(`OFS_CTRL);
        chk({30'h0, hresp, rd[`CTRL_BUSY]}, 32'h1);
        while (rd[`CTRL_BUSY] !== 1'b0 && c < 40) begin
            rdr(`OFS_CTRL);
            c++;
        end
        if (c >= 40) chk(rd, 32'h0);
    endtask : exec

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    initial begin
        #150000;
        n_mismatch++;
        complete_run();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        hresetn = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; n_mismatch = 0; n_tests = 0;
        zoff = '{`OFS_WREG, `OFS_PROD, `OFS_FLAGS, `OFS_BANK, `OFS_PC, `OFS_STACK, `OFS_INDEX, 8'h40};
        void'($urandom(12));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rdr(`OFS_PROD);
        chk(rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 8'hE2 : 8'($urandom);
            v = (i == 0) ? 8'hC4 : 8'($urandom);
            op = {11'h0, 5'($urandom)};
            wr(`OFS_WREG, {24'h0, w});
            wr(`OFS_FLAGS, {16'h0, op});
            exec({8'h0D, v});
            rdr(`OFS_PROD);
            chk(rd, {16'h0, mulx(w, v)});
            rdr(`OFS_WREG);
            chk(rd, {24'h0, w});
            rdr(`OFS_FLAGS);
            chk(rd, {16'h0, op});
        end
        for (int i = 0; i < 8; i++) begin
            ext = i[1];
            bk = 4'($urandom);
            idx = 12'($urandom);
            w = 8'($urandom);
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 3) ? 8'h3A : 8'($urandom);
            f = (i == 2) ? 8'h5F : (i == 6) ? 8'h60 : (i[2] ? 8'($urandom_range(95)) : 8'($urandom));
            ma = ea(i[0], f);
            wr(`OFS_CTRL, {31'h0, ext});
            wr(`OFS_BANK, {28'h0, bk});
            wr(`OFS_INDEX, {20'h0, idx});
            wr(`OFS_WREG, {24'h0, w});
            wr(`OFS_MADDR, {20'h0, ma});
            wr(`OFS_MDATA, {24'h0, v});
            exec({7'b0000001, i[0], f});
            rdr(`OFS_PROD);
            chk(rd, {16'h0, mulx(w, v)});
            rdr(`OFS_WREG);
            chk(rd, {24'h0, w});
            rdr(`OFS_MDATA);
            chk(rd, {24'h0, v});
            exec({7'b0110110, i[0], f});
            rdr(`OFS_MDATA);
            chk(rd, {24'h0, 8'(-v)});
            rdr(`OFS_FLAGS);
            chk(rd, nfl(v));
        end
        pc = 21'($urandom) & 21'h1FFFFE;
        wr(`OFS_PC, {11'h0, pc});
        sp = 0;
        for (int i = 0; i < 7; i++) begin
            op = (i == 0) ? 16'h0005 : (i == 1) ? 16'hDC00 : (i == 2) ? 16'hDBFF : (i == 3) ? 16'h0000 : 16'h0006;
            exec(op);
            if (i < 3) tosq[sp] = pc + 21'h2;
            if (i < 3) sp++;
            if (i > 3) sp--;
            pc = pc + 21'h2 + ((i == 1 || i == 2) ? {{9{op[10]}}, op[10:0], 1'b0} : 21'h0);
            rdr(`OFS_PC);
            chk(rd, {11'h0, pc});
            rdr(`OFS_STACK);
            chk({27'h0, rd[28:24]}, 32'(sp));
            if (sp > 0) chk({11'h0, rd[20:0]}, {11'h0, tosq[sp - 1]});
        end
        wr(`OFS_WREG, 32'h5A);
        wr(`OFS_BANK, 32'h5);
        wr(`OFS_CTRL, 32'h1);
        exec(16'h00FF);
        for (int i = 0; i < 8; i++) begin
            rdr(zoff[i]);
            chk(rd, 32'h0);
        end
        rdr(`OFS_CTRL);
        chk(rd, 32'h1);
        complete_run();
    end
endmodule : tb
`default_nettype wire
